//--- spi_flash_defines.svh
/*
 holds register offsets, field positions, reset values and flash commands
 assumes byte addresses on a classic wishbone bus with 32-bit data
*/
// How it works
// - read command 0x03 normally, 0x0b when quick read is selected
// - chip select stays high at least select_gap_cycles serial clocks between transfers
// - serial clock equals system clock divided by the divisor field
// - pin override enable hands the serial pins to software
// - in override the serial clock pin follows the override clock value
// - in override the clock driver is on only with its drive enable
// - in override the data out pin follows the override data value
// - in override the data out driver is on only with its drive enable
// - in override the select pin follows the override select value
// - in override the select driver is on only with its drive enable
// - override register bit 0 reads the sampled serial data input level
`ifndef SPI_FLASH_DEFINES_SVH
`define SPI_FLASH_DEFINES_SVH
`define CFG_OFS 8'h00
`define OVR_OFS 8'h14
`define CFG_QUICK_BIT 10
`define CFG_GAP_LSB 5
`define CFG_DIV_LSB 0
`define CFG_GAP_RST 5'h1f
`define CFG_DIV_RST 5'h1f
`define OVR_EN_BIT 13
`define OVR_SCLK_BIT 12
`define OVR_SCLK_OE_BIT 11
`define OVR_MOSI_BIT 10
`define OVR_MOSI_OE_BIT 9
`define OVR_CS_BIT 5
`define OVR_CS_OE_BIT 1
`define OVR_MISO_BIT 0
`define CMD_READ 8'h03
`define CMD_QUICK 8'h0b
`define LEAD_BITS 7'h20
`define LEAD_QUICK_BITS 7'h28
`define DATA_BITS 7'h20
`endif

//--- spi_flash_pkg.sv
/*
 holds the types of the flash read master
 assumes nothing of its surroundings
*/
package spi_flash_pkg;
	typedef enum logic [1:0] {st_idle, st_shift, st_gap} state_t;
	typedef logic [4:0] field5_t;
endpackage : spi_flash_pkg

//--- spi_flash_master.sv
/*
 flash read master with a software pin override mode and a wishbone slave
 assumes miso_i is asynchronous, the bus is classic wishbone, one clock
*/
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spi_flash_defines.svh"
module spi_flash_master
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic rd_req_i,
	input wire logic [23:0] rd_addr_i,
	output logic rd_busy_o,
	output logic rd_done_o,
	output logic [31:0] rd_data_o,
	output logic sclk_o,
	output logic sclk_oe_n_o,
	output logic mosi_o,
	output logic mosi_oe_n_o,
	output logic cs_n_o,
	output logic cs_oe_n_o,
	input wire logic miso_i
);
	import spi_flash_pkg::*;

	logic quick;
	spi_flash_pkg::field5_t gap;
	spi_flash_pkg::field5_t div;
	logic [31:0] ovr;
	logic ovr_en;
	logic miso_a;
	logic miso_s;
	state_t state;
	logic [4:0] ph;
	logic [6:0] bitcnt;
	logic [6:0] total;
	logic [6:0] lead;
	logic [4:0] gapcnt;
	logic [39:0] sr;
	logic [31:0] shin;
	logic sclk_eng;
	logic cs_eng;
	logic mosi_eng;
	logic start;
	logic period_end;
	logic [31:0] cfg_word;
	logic [31:0] cfg_merged;
	logic [2:0] take_d;
	logic [2:0] last_d;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction : merge

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////
	// input synchroniser
	always_ff @(posedge clk_i)
	begin
		miso_a <= miso_i;
		miso_s <= miso_a;
	end

	////////////////////////////////////////////////////////////////////////////
	// wishbone slave
	logic bus_hit;
	assign bus_hit = cyc_i && stb_i && !ack_o;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= bus_hit;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			quick <= 1'b0;
			gap <= `CFG_GAP_RST;
			div <= `CFG_DIV_RST;
		end
		else if (bus_hit && we_i && adr_i == `CFG_OFS)
		begin
			quick <= cfg_merged[`CFG_QUICK_BIT];
			gap <= cfg_merged[`CFG_GAP_LSB +: 5];
			div <= cfg_merged[`CFG_DIV_LSB +: 5];
		end
	end

	assign cfg_word = {21'h0, quick, gap, div};
	assign cfg_merged = merge(cfg_word, dat_i, sel_i);

	localparam logic [31:0] OVR_MASK = 32'h00003e22;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ovr <= 32'h0;
		else if (bus_hit && we_i && adr_i == `OVR_OFS)
			ovr <= merge(ovr, dat_i, sel_i) & OVR_MASK;
	end

	assign ovr_en = ovr[`OVR_EN_BIT];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= 32'h0;
		else if (bus_hit && !we_i && adr_i == `CFG_OFS)
			dat_o <= cfg_word;
		else if (bus_hit && !we_i && adr_i == `OVR_OFS)
			dat_o <= {ovr[31:1], miso_s};
		else
			dat_o <= 32'h0;
	end

	a_miso_readback: assert property (ack_o && $past(!we_i && adr_i == `OVR_OFS)
		|-> dat_o[0] == $past(miso_s)) else $error("miso level not read back");

	////////////////////////////////////////////////////////////////////////////
	// read engine
	assign lead = quick ? `LEAD_QUICK_BITS : `LEAD_BITS;
	assign total = 7'(lead + `DATA_BITS);
	assign start = state == st_idle && rd_req_i && !ovr_en;
	assign period_end = ph == 5'(div - 5'h1);

	always_ff @(posedge clk_i)
	begin
		if (rst_i || state == st_idle || period_end)
			ph <= 5'h0;
		else
			ph <= 5'(ph + 5'h1);
	end

	// miso capture delayed past pin register and synchroniser
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			take_d <= 3'h0;
			last_d <= 3'h0;
		end
		else
		begin
			take_d <= {take_d[1:0], state == st_shift && ph == (div >> 1) && bitcnt >= lead};
			last_d <= {last_d[1:0], state == st_shift && ph == (div >> 1)
				&& bitcnt == 7'(total - 7'h1)};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= st_idle;
			cs_eng <= 1'b1;
			sclk_eng <= 1'b0;
			mosi_eng <= 1'b0;
			bitcnt <= 7'h0;
			gapcnt <= 5'h0;
			sr <= 40'h0;
			shin <= 32'h0;
			rd_busy_o <= 1'b0;
			rd_done_o <= 1'b0;
			rd_data_o <= 32'h0;
		end
		else
		begin
			rd_done_o <= 1'b0;
			if (take_d[2])
				shin <= {shin[30:0], miso_s};
			if (last_d[2])
			begin
				rd_data_o <= {shin[30:0], miso_s};
				rd_done_o <= 1'b1;
			end
			unique case (state)
				st_idle:
				begin
					if (start)
					begin
						state <= st_shift;
						cs_eng <= 1'b0;
						bitcnt <= 7'h0;
						rd_busy_o <= 1'b1;
						sr <= {quick ? `CMD_QUICK : `CMD_READ, rd_addr_i, 8'h00};
					end
				end
				st_shift:
				begin
					if (ph == 5'h0)
					begin
						sclk_eng <= 1'b0;
						mosi_eng <= sr[39];
						sr <= {sr[38:0], 1'b0};
					end
					if (ph == (div >> 1))
					begin
						sclk_eng <= 1'b1;
						bitcnt <= 7'(bitcnt + 7'h1);
					end
					if (period_end && bitcnt == total)
					begin
						state <= st_gap;
						sclk_eng <= 1'b0;
						cs_eng <= 1'b1;
						gapcnt <= 5'h0;
					end
				end
				st_gap:
				begin
					if (period_end && gapcnt != gap)
						gapcnt <= 5'(gapcnt + 5'h1);
					if (gapcnt == gap && last_d == 3'h0)
					begin
						state <= st_idle;
						rd_busy_o <= 1'b0;
					end
				end
			endcase
		end
	end

	a_cmd_select: assert property (state == st_shift && $past(state) == st_idle
		|-> sr[39:32] == ($past(quick) ? `CMD_QUICK : `CMD_READ))
		else $error("wrong read command");
	a_override_blocks: assert property (ovr_en && state == st_idle |=> state == st_idle)
		else $error("engine started under override");
	a_done_in_busy: assert property (rd_done_o |-> rd_busy_o && state == st_gap)
		else $error("read done outside the select gap");

	////////////////////////////////////////////////////////////////////////////
	// checking helpers for gap and clock period
	logic [11:0] cs_high_cnt;
	logic [5:0] rise_gap;
	logic rise_seen;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cs_high_cnt <= 12'hfff;
		else if (!cs_eng)
			cs_high_cnt <= 12'h0;
		else if (cs_high_cnt != 12'hfff)
			cs_high_cnt <= 12'(cs_high_cnt + 12'h1);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || state != st_shift)
		begin
			rise_gap <= 6'h0;
			rise_seen <= 1'b0;
		end
		else if ($rose(sclk_eng))
		begin
			rise_gap <= 6'h0;
			rise_seen <= 1'b1;
		end
		else
			rise_gap <= 6'(rise_gap + 6'h1);
	end

	a_gap_length: assert property ($fell(cs_eng) && $past(cs_high_cnt) != 12'hfff
		|-> $past(cs_high_cnt) >= 12'(gap) * 12'(div)) else $error("select gap too short");
	a_clock_period: assert property ($rose(sclk_eng) && rise_seen
		|-> rise_gap == 6'(div - 5'h1)) else $error("serial clock period wrong");

	////////////////////////////////////////////////////////////////////////////
	// pin drivers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sclk_o <= 1'b0;
			sclk_oe_n_o <= 1'b0;
			mosi_o <= 1'b0;
			mosi_oe_n_o <= 1'b0;
			cs_n_o <= 1'b1;
			cs_oe_n_o <= 1'b0;
		end
		else if (ovr_en)
		begin
			sclk_o <= ovr[`OVR_SCLK_BIT];
			sclk_oe_n_o <= !ovr[`OVR_SCLK_OE_BIT];
			mosi_o <= ovr[`OVR_MOSI_BIT];
			mosi_oe_n_o <= !ovr[`OVR_MOSI_OE_BIT];
			cs_n_o <= ovr[`OVR_CS_BIT];
			cs_oe_n_o <= !ovr[`OVR_CS_OE_BIT];
		end
		else
		begin
			sclk_o <= sclk_eng;
			sclk_oe_n_o <= 1'b0;
			mosi_o <= mosi_eng;
			mosi_oe_n_o <= 1'b0;
			cs_n_o <= cs_eng;
			cs_oe_n_o <= 1'b0;
		end
	end

	a_ovr_sclk: assert property ($past(ovr_en) |-> sclk_o == $past(ovr[`OVR_SCLK_BIT]))
		else $error("override clock value lost");
	a_ovr_sclk_oe: assert property ($past(ovr_en)
		|-> sclk_oe_n_o != $past(ovr[`OVR_SCLK_OE_BIT])) else $error("clock enable wrong");
	a_ovr_mosi: assert property ($past(ovr_en) |-> mosi_o == $past(ovr[`OVR_MOSI_BIT])
		&& mosi_oe_n_o != $past(ovr[`OVR_MOSI_OE_BIT])) else $error("data out override");
	a_ovr_cs: assert property ($past(ovr_en) |-> cs_n_o == $past(ovr[`OVR_CS_BIT])
		&& cs_oe_n_o != $past(ovr[`OVR_CS_OE_BIT])) else $error("select override");
	a_engine_pins: assert property (!$past(ovr_en) |-> !sclk_oe_n_o && !mosi_oe_n_o
		&& !cs_oe_n_o && cs_n_o == $past(cs_eng) && sclk_o == $past(sclk_eng))
		else $error("engine does not own pins");
endmodule : spi_flash_master
`default_nettype wire

//--- flash_model.sv
/*
 behavioural serial flash answering mode 0 reads with a fixed word
 assumes pins resolved by the bench, select released high
*/
`timescale 1ns/1ps
`default_nettype none
module flash_model
#(
	parameter logic [31:0] WORD = 32'hc3a55a3c
)
(
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic miso_o
);
	logic [39:0] rx;
	logic [7:0] cmd;
	logic [23:0] addr;
	int n;
	int lead;
	initial
	begin
		rx = '0;
		cmd = '0;
		addr = '0;
		n = 0;
		miso_o = 1'b1;
	end
	assign lead = (cmd == 8'h0b) ? 40 : 32;
	always @(negedge cs_n_i) n = 0;
	// capture command and address on rising clock
	always @(posedge sclk_i)
		if (!cs_n_i)
		begin
			rx = {rx[38:0], mosi_i};
			n = n + 1;
			if (n == 8) cmd = rx[7:0];
			if (n == 32) addr = rx[23:0];
		end
	// data on falling clock, a changing level when not driving
	always @(negedge sclk_i or posedge cs_n_i)
		if (!cs_n_i && n >= lead && n < lead + 32) miso_o = WORD[31 - (n - lead)];
		else miso_o = ~miso_o;
endmodule : flash_model
`default_nettype wire

//--- test_spi_flash_master.sv
/*
 register, read engine and pin override tests of the flash read master
 assumes flash_model compiled before it
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
$display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_spi_flash_master;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, rd_req_i = 0;
	logic [7:0] adr_i = 0;
	logic [3:0] sel_i = 0;
	logic [31:0] dat_i = 0, dat_o, rd_data_o, q, w;
	logic [23:0] rd_addr_i = 0;
	logic ack_o, rd_busy_o, rd_done_o, sclk_o, sclk_oe_n_o, mosi_o, mosi_oe_n_o;
	logic cs_n_o, cs_oe_n_o, miso_i, sq = 0, cq = 1;
	logic [1:0] v;
	int miscompares = 0, n_checks = 0, cnt = 0, per = 0, hi = 0, gapm = 0;
	always #4 clk_i = ~clk_i;
	spi_flash_master u_spi_flash_master (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .rd_req_i, .rd_addr_i, .rd_busy_o, .rd_done_o,
		.rd_data_o, .sclk_o, .sclk_oe_n_o, .mosi_o, .mosi_oe_n_o, .cs_n_o, .cs_oe_n_o,
		.miso_i);
	flash_model u_flash_model (.sclk_i(sclk_oe_n_o ? 1'b0 : sclk_o),
		.cs_n_i(cs_oe_n_o ? 1'b1 : cs_n_o), .mosi_i(mosi_oe_n_o ? 1'b1 : mosi_o),
		.miso_o(miso_i));
	////////////////////////////////////////////////////////////////////////////////
	// clock period and select high time
	always @(posedge clk_i)
	begin
		cnt <= (sclk_o && !sq) ? 1 : cnt + 1;
		if (sclk_o && !sq) per <= cnt;
		hi <= cs_n_o ? hi + 1 : 0;
		if (!cs_n_o && cq) gapm <= hi;
		sq <= sclk_o;
		cq <= cs_n_o;
	end
	task stop_test;
		if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= wr;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		we_i <= 0;
		@(posedge clk_i);
	endtask : wb
	task rd(input logic [23:0] a);
		rd_addr_i <= a;
		rd_req_i <= 1;
		do @(posedge clk_i); while (rd_busy_o !== 1'b0);
		do @(posedge clk_i); while (rd_busy_o !== 1'b1);
		rd_req_i <= 0;
		do @(posedge clk_i); while (rd_done_o !== 1'b1);
	endtask : rd
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		stop_test();
	end
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		wb(0, 8'h00, 0);
		`CHK(q, 32'h000003ff)
		wb(0, 8'h14, 0);
		`CHK(q & 32'hfffffffe, 32'h0)
		wb(0, 8'h08, 0);
		`CHK(q, 32'h0)
		wb(1, 8'h00, 32'h44);
		rd(24'h123456);
		`CHK(rd_data_o, 32'hc3a55a3c)
		`CHK(u_flash_model.cmd, 8'h03)
		`CHK(u_flash_model.addr, 24'h123456)
		`CHK(per, 4)
		rd(24'h000010);
		`CHK(gapm >= 8, 1'b1)
		wb(1, 8'h00, 32'h445);
		rd(24'habcdef);
		`CHK(rd_data_o, 32'hc3a55a3c)
		`CHK(u_flash_model.cmd, 8'h0b)
		`CHK(u_flash_model.addr, 24'habcdef)
		`CHK(per, 5)
		for (int i = 0; i < 4; i++)
		begin
			v = i[1:0];
			w = {18'h0, 1'b1, v[0], v[1], !v[0], v[0], 3'b0, v[1], 3'b0, !v[1], 1'b0};
			wb(1, 8'h14, w);
			repeat (4) @(posedge clk_i);
			`CHK({sclk_o, sclk_oe_n_o, mosi_o, mosi_oe_n_o, cs_n_o, cs_oe_n_o},
				{v[0], !v[1], !v[0], !v[0], v[1], v[1]})
			wb(0, 8'h14, 0);
			`CHK(q & 32'hfffffffe, w)
			`CHK(q[0], miso_i)
		end
		rd_req_i <= 1;
		repeat (20) @(posedge clk_i);
		`CHK(rd_busy_o, 1'b0)
		rd_req_i <= 0;
		wb(1, 8'h14, 32'h1e22);
		repeat (4) @(posedge clk_i);
		`CHK({sclk_o, sclk_oe_n_o, mosi_oe_n_o, cs_n_o, cs_oe_n_o}, 5'b00010)
		stop_test();
	end
endmodule : test_spi_flash_master
`default_nettype wire
